/* common/sdc_pkg.sv */
// Operation
// - Read data driven n+m-1, valid n+m
// - Column commands accepted on consecutive cycles
// - Clock enable acts one cycle after sampling
// - Write byte mask acts same cycle
// - Read byte mask floats outputs two later
// - First write word taken with command
// - Precharge floats read outputs after latency
// - Four banks, 4096 rows, 256 columns
// - Mode word kept until next load
// - Mode word field layout decoded
// - Lengths 1,2,4,8 and sequential full page
// - Burst wraps inside aligned column block
// - Sequential increments, interleaved XORs beat count
// - Full page wraps in row until stopped
// - Nonzero operating mode bits not normal
// - Write burst mode bit forces single writes
package sdc_pkg;

	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;                   // Address pins
	localparam int ROW_W  = 12;                   // Row bits
	localparam int COL_W  = 8;                    // Column bits
	localparam int BANK_W = 2;                    // Bank bits
	localparam int NBANK  = 4;                    // Banks
	localparam int BYTE_W = 8;                    // Byte lane width
	localparam int BYTES  = 2;                    // Byte lanes
	localparam int DQ_W   = BYTE_W * BYTES;       // Data width
	localparam int MEM_AW = BANK_W + ROW_W + COL_W; // Word address
	localparam int AP_BIT = 10;                   // Auto precharge / all banks

	// ----------------------------------------------------------------
	// Timing in cycles
	// ----------------------------------------------------------------
	localparam int DQM_RD_LAT = 2;                // Read mask to float

	// ----------------------------------------------------------------
	// Mode word layout
	// ----------------------------------------------------------------
	localparam int MODE_W    = 12;
	localparam int BL_LSB    = 0;
	localparam int BL_MSB    = 2;
	localparam int ORDER_BIT = 3;
	localparam int CL_LSB    = 4;
	localparam int CL_MSB    = 6;
	localparam int OPM_LSB   = 7;
	localparam int OPM_MSB   = 8;
	localparam int WBM_BIT   = 9;
	localparam logic [2:0] BL_1       = 3'h0;
	localparam logic [2:0] BL_2       = 3'h1;
	localparam logic [2:0] BL_4       = 3'h2;
	localparam logic [2:0] BL_8       = 3'h3;
	localparam logic [2:0] BL_FULL    = 3'h7;
	localparam logic [2:0] CL_CODE_2  = 3'h2;
	localparam logic [1:0] OPM_NORMAL = 2'h0;
	localparam logic [COL_W-1:0] MASK_1    = 8'h00;
	localparam logic [COL_W-1:0] MASK_2    = 8'h01;
	localparam logic [COL_W-1:0] MASK_4    = 8'h03;
	localparam logic [COL_W-1:0] MASK_8    = 8'h07;
	localparam logic [COL_W-1:0] MASK_FULL = 8'hFF;

	// ----------------------------------------------------------------
	// Command pin patterns {row strobe, column strobe, write enable}
	// ----------------------------------------------------------------
	localparam logic [2:0] P_NOP = 3'h7;
	localparam logic [2:0] P_ACT = 3'h3;
	localparam logic [2:0] P_RD  = 3'h5;
	localparam logic [2:0] P_WR  = 3'h4;
	localparam logic [2:0] P_BST = 3'h6;
	localparam logic [2:0] P_PRE = 3'h2;
	localparam logic [2:0] P_REF = 3'h1;
	localparam logic [2:0] P_LMR = 3'h0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_BST, CMD_PRE, CMD_REF, CMD_LMR
	} sdc_cmd_t;

	typedef enum logic [1:0] {BS_IDLE, BS_READ, BS_WRITE} sdc_bst_t;

	typedef struct packed {
		logic              v;
		logic [MEM_AW-1:0] addr;
	} sdc_beat_t;

	typedef struct packed {
		sdc_bst_t          mode;
		logic [BANK_W-1:0] bank;
		logic [ROW_W-1:0]  row;
		logic [COL_W-1:0]  start;
		logic [COL_W-1:0]  beat;
		logic              ap;
	} sdc_brst_t;

	typedef struct packed {
		logic                                cke;
		logic [MODE_W-1:0]                   mode;
		logic [NBANK-1:0]                    open;
		logic [NBANK-1:0][ROW_W-1:0]         row;
		sdc_brst_t                           b;
		sdc_beat_t                           p1;
		logic                                out_v;
		logic [BYTES-1:0]                    oe;
		logic [DQM_RD_LAT-1:0][BYTES-1:0]    dqm_pipe;
	} sdc_state_t;

endpackage

/* rtl/sdc_burst_col.sv */
`timescale 1ns/1ps
// --------------------------------------------------------------------
// Column of the current beat within its burst block
// --------------------------------------------------------------------
module sdc_burst_col (
	input  wire logic [2:0]               len_code,
	input  wire logic                     single,
	input  wire logic                     ilv,
	input  wire logic [sdc_pkg::COL_W-1:0] start,
	input  wire logic [sdc_pkg::COL_W-1:0] beat,
	output logic      [sdc_pkg::COL_W-1:0] mask,
	output logic                          full,
	output logic      [sdc_pkg::COL_W-1:0] col
);
	logic [sdc_pkg::COL_W-1:0] seq_off; // Sequential offset before masking

	// Length code to block mask; reserved codes fall back to one beat
	always_comb begin
		full = 1'b0;
		unique case (len_code)
			sdc_pkg::BL_1:    mask = sdc_pkg::MASK_1;
			sdc_pkg::BL_2:    mask = sdc_pkg::MASK_2;
			sdc_pkg::BL_4:    mask = sdc_pkg::MASK_4;
			sdc_pkg::BL_8:    mask = sdc_pkg::MASK_8;
			sdc_pkg::BL_FULL: begin
				mask = sdc_pkg::MASK_FULL;
				full = 1'b1;
			end
			default:          mask = sdc_pkg::MASK_1;
		endcase
		if (single) begin
			mask = sdc_pkg::MASK_1;
			full = 1'b0;
		end
	end

	// Upper bits fix the block, low bits walk and wrap inside it
	always_comb begin
		seq_off = start + beat;
		if (ilv && !full) begin
			col = (start & ~mask) | ((start ^ beat) & mask);
		end else begin
			col = (start & ~mask) | (seq_off & mask);
		end
	end
endmodule // sdc_burst_col

/* rtl/sdc_core.sv */
`timescale 1ns/1ps
// --------------------------------------------------------------------
// Synchronous DRAM core: command decode, banks, bursts, data path
// --------------------------------------------------------------------
module sdc_core (
	input  wire logic                        SYS_CLK,
	input  wire logic                        RST_N,
	input  wire logic                        CKE,
	input  wire logic                        CS_N,
	input  wire logic                        RAS_N,
	input  wire logic                        CAS_N,
	input  wire logic                        WE_N,
	input  wire logic                        BANK_SELECT_LO,
	input  wire logic                        BANK_SELECT_HI,
	input  wire logic [sdc_pkg::ADDR_W-1:0]  ADDR,
	input  wire logic [sdc_pkg::BYTES-1:0]   DQM,
	input  wire logic [sdc_pkg::DQ_W-1:0]    DQ_IN,
	output logic      [sdc_pkg::DQ_W-1:0]    DQ_OUT,
	output logic      [sdc_pkg::BYTES-1:0]   DQ_OE
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	sdc_pkg::sdc_state_t              st_r;      // All control state
	sdc_pkg::sdc_state_t              st_nxt;    // Its next value
	sdc_pkg::sdc_cmd_t                cmd;       // Decoded command
	logic [sdc_pkg::BANK_W-1:0]       ba;        // Bank pins
	logic [sdc_pkg::COL_W-1:0]        col_in;    // Start column pins
	logic [sdc_pkg::COL_W-1:0]        bcol;      // Column of current beat
	logic [sdc_pkg::COL_W-1:0]        bmask;     // Block mask
	logic                             bfull;     // Full page burst
	logic                             lat3;      // Latency three selected
	logic                             opm_ok;    // Normal operating mode
	logic                             wr_one;    // Write is one beat only
	logic                             last_beat; // Burst ends on this beat
	logic                             emit_rd;   // Read beat this cycle
	logic                             emit_wr;   // Write beat this cycle
	logic                             acc_rd;    // Read taken
	logic                             acc_wr;    // Write taken
	logic [sdc_pkg::MEM_AW-1:0]       cur_addr;  // Word of current beat
	logic [sdc_pkg::MEM_AW-1:0]       waddr;     // Write word
	logic [sdc_pkg::MEM_AW-1:0]       raddr;     // Read word
	logic                             rvalid;    // Read word wanted
	logic [sdc_pkg::BYTES-1:0]        we;        // Byte write strobes

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	assign ba     = {BANK_SELECT_HI, BANK_SELECT_LO};
	assign col_in = ADDR[sdc_pkg::COL_W-1:0];

	// Deselected chip is treated as an idle command
	always_comb begin
		cmd = sdc_pkg::CMD_NOP;
		if (!CS_N) begin
			unique case ({RAS_N, CAS_N, WE_N})
				sdc_pkg::P_NOP: cmd = sdc_pkg::CMD_NOP;
				sdc_pkg::P_ACT: cmd = sdc_pkg::CMD_ACT;
				sdc_pkg::P_RD:  cmd = sdc_pkg::CMD_RD;
				sdc_pkg::P_WR:  cmd = sdc_pkg::CMD_WR;
				sdc_pkg::P_BST: cmd = sdc_pkg::CMD_BST;
				sdc_pkg::P_PRE: cmd = sdc_pkg::CMD_PRE;
				sdc_pkg::P_REF: cmd = sdc_pkg::CMD_REF;
				sdc_pkg::P_LMR: cmd = sdc_pkg::CMD_LMR;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Mode decode and burst walk
	// ----------------------------------------------------------------
	assign lat3   = st_r.mode[sdc_pkg::CL_MSB:sdc_pkg::CL_LSB] != sdc_pkg::CL_CODE_2;
	assign opm_ok = st_r.mode[sdc_pkg::OPM_MSB:sdc_pkg::OPM_LSB] == sdc_pkg::OPM_NORMAL;

	sdc_burst_col i_sdc_burst_col (
		.len_code (st_r.mode[sdc_pkg::BL_MSB:sdc_pkg::BL_LSB]),
		.single   (st_r.mode[sdc_pkg::WBM_BIT] && st_r.b.mode == sdc_pkg::BS_WRITE),
		.ilv      (st_r.mode[sdc_pkg::ORDER_BIT]),
		.start    (st_r.b.start),
		.beat     (st_r.b.beat),
		.mask     (bmask),
		.full     (bfull),
		.col      (bcol)
	);

	// Column commands only land in an open bank under normal mode
	assign acc_rd    = st_r.cke && cmd == sdc_pkg::CMD_RD && st_r.open[ba] && opm_ok;
	assign acc_wr    = st_r.cke && cmd == sdc_pkg::CMD_WR && st_r.open[ba] && opm_ok;
	assign wr_one    = st_r.mode[sdc_pkg::WBM_BIT] || (bmask == sdc_pkg::MASK_1 && !bfull);
	assign last_beat = !bfull && st_r.b.beat == bmask;
	assign emit_rd   = st_r.b.mode == sdc_pkg::BS_READ;
	assign emit_wr   = st_r.b.mode == sdc_pkg::BS_WRITE;
	assign cur_addr  = {st_r.b.bank, st_r.b.row, bcol};

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// Whole core freezes while the previous edge saw clock enable low
	always_comb begin
		st_nxt     = st_r;
		st_nxt.cke = CKE;
		if (st_r.cke) begin
			// Mask history for the read output float
			st_nxt.dqm_pipe = {st_r.dqm_pipe[sdc_pkg::DQM_RD_LAT-2:0], DQM};
			// Advance a running burst; auto precharge closes at its end
			if (st_r.b.mode != sdc_pkg::BS_IDLE) begin
				if (last_beat) begin
					st_nxt.b.mode = sdc_pkg::BS_IDLE;
					if (st_r.b.ap) begin
						st_nxt.open[st_r.b.bank] = 1'b0;
					end
				end else begin
					st_nxt.b.beat = st_r.b.beat + 1'b1;
				end
			end
			// Read pipe: one extra stage at latency three
			st_nxt.p1    = '{v: emit_rd, addr: cur_addr};
			st_nxt.out_v = lat3 ? st_r.p1.v : emit_rd;
			unique case (cmd)
				sdc_pkg::CMD_ACT: begin
					st_nxt.open[ba] = 1'b1;
					st_nxt.row[ba]  = ADDR[sdc_pkg::ROW_W-1:0];
				end
				sdc_pkg::CMD_RD: begin
					// A new read truncates whatever burst runs
					if (acc_rd) begin
						st_nxt.b = '{mode: sdc_pkg::BS_READ, bank: ba, row: st_r.row[ba],
							start: col_in, beat: '0, ap: ADDR[sdc_pkg::AP_BIT]};
					end
				end
				sdc_pkg::CMD_WR: begin
					if (acc_wr) begin
						// Write takes the bus: read data is dropped at once
						st_nxt.p1.v  = 1'b0;
						st_nxt.out_v = 1'b0;
						st_nxt.b = '{mode: sdc_pkg::BS_WRITE, bank: ba, row: st_r.row[ba],
							start: col_in, beat: 8'h01, ap: ADDR[sdc_pkg::AP_BIT]};
						if (wr_one) begin
							st_nxt.b.mode = sdc_pkg::BS_IDLE;
							if (ADDR[sdc_pkg::AP_BIT]) begin
								st_nxt.open[ba] = 1'b0;
							end
						end
					end
				end
				sdc_pkg::CMD_BST: st_nxt.b.mode = sdc_pkg::BS_IDLE;
				sdc_pkg::CMD_PRE: begin
					// Closing the burst bank stops its data after the latency
					if (ADDR[sdc_pkg::AP_BIT]) begin
						st_nxt.open   = '0;
						st_nxt.b.mode = sdc_pkg::BS_IDLE;
					end else begin
						st_nxt.open[ba] = 1'b0;
						if (ba == st_r.b.bank) begin
							st_nxt.b.mode = sdc_pkg::BS_IDLE;
						end
					end
				end
				sdc_pkg::CMD_LMR: st_nxt.mode = ADDR[sdc_pkg::MODE_W-1:0];
				sdc_pkg::CMD_NOP, sdc_pkg::CMD_REF: ;
			endcase
			// Read mask taken two edges ago floats its lane
			st_nxt.oe = {sdc_pkg::BYTES{st_nxt.out_v}}
				& ~st_r.dqm_pipe[sdc_pkg::DQM_RD_LAT-1];
		end
	end

	// State register; reset clears the mode word along with the rest of the state
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	// Beats at a read, stop or precharge edge are ignored, as the
	// controller keeps a gap after its last write word
	assign waddr  = acc_wr ? {ba, st_r.row[ba], col_in} : cur_addr;
	assign raddr  = lat3 ? st_r.p1.addr : cur_addr;
	assign rvalid = lat3 ? st_r.p1.v : emit_rd;
	assign we     = {sdc_pkg::BYTES{acc_wr || (st_r.cke && emit_wr && cmd != sdc_pkg::CMD_RD
		&& cmd != sdc_pkg::CMD_BST && cmd != sdc_pkg::CMD_PRE)}} & ~DQM;

	// One array per byte lane keeps each lane single-driven
	genvar gi;
	generate
		for (gi = 0; gi < sdc_pkg::BYTES; gi++) begin : g_lane
			logic [sdc_pkg::BYTE_W-1:0] mem [0:(1 << sdc_pkg::MEM_AW)-1]; // Lane cells
			logic [sdc_pkg::BYTE_W-1:0] rd_q_r;                           // Lane output

			always_ff @(posedge SYS_CLK) begin
				if (we[gi]) begin
					mem[waddr] <= DQ_IN[gi*sdc_pkg::BYTE_W +: sdc_pkg::BYTE_W];
				end
			end

			// Output word held while no beat is due
			always_ff @(posedge SYS_CLK or negedge RST_N) begin
				if (!RST_N) begin
					rd_q_r <= '0;
				end else if (st_r.cke && rvalid) begin
					rd_q_r <= mem[raddr];
				end
			end
			assign DQ_OUT[gi*sdc_pkg::BYTE_W +: sdc_pkg::BYTE_W] = rd_q_r;
		end
	endgenerate

	assign DQ_OE = st_r.oe;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	sequence s_rd_keep;
		st_r.cke && !acc_wr;
	endsequence
	sequence s_cl3_go;
		acc_rd && lat3 && !emit_rd;
	endsequence

	AST_CL2_START: assert property (acc_rd && !lat3 ##1 s_rd_keep |=> st_r.out_v)
		else $error("latency two read not driven on time");
	AST_CL3_START: assert property (acc_rd && lat3 ##1 s_rd_keep [*2] |=> st_r.out_v)
		else $error("latency three read not driven on time");
	AST_CL3_EARLY: assert property (s_cl3_go ##1 s_rd_keep |=> !st_r.out_v)
		else $error("latency three read driven early");
	AST_BACK2BACK: assert property (acc_rd |=> st_r.b.mode == sdc_pkg::BS_READ
		&& st_r.b.start == $past(col_in) && st_r.b.beat == '0)
		else $error("read command not taken");
	AST_SUSPEND: assert property (!st_r.cke |=> $stable(st_r.b) && $stable(DQ_OUT))
		else $error("state moved during suspend");
	AST_WR_MASK: assert property (acc_wr |-> we == ~DQM
		&& waddr == {ba, st_r.row[ba], col_in})
		else $error("first write word not masked or placed");
	// Unmasked first word must really sit in both lanes one edge later
	AST_WR_LAND: assert property (acc_wr && DQM == '0 |=>
		{g_lane[1].mem[{$past(ba), st_r.row[$past(ba)], $past(col_in)}],
		g_lane[0].mem[{$past(ba), st_r.row[$past(ba)], $past(col_in)}]} == $past(DQ_IN))
		else $error("first write word not stored");
	AST_DQM_RD: assert property (st_r.cke && DQM[0] ##1 st_r.cke [*2] |=> !DQ_OE[0])
		else $error("read mask did not float lane");
	AST_PRE_CL2: assert property (st_r.cke && cmd == sdc_pkg::CMD_PRE
		&& (ADDR[sdc_pkg::AP_BIT] || ba == st_r.b.bank)
		&& !lat3 ##1 st_r.cke |=> DQ_OE == '0)
		else $error("outputs live after precharge at latency two");
	AST_PRE_CL3: assert property (st_r.cke && cmd == sdc_pkg::CMD_PRE
		&& (ADDR[sdc_pkg::AP_BIT] || ba == st_r.b.bank)
		&& lat3 ##1 st_r.cke [*2] |=> DQ_OE == '0)
		else $error("outputs live after precharge at latency three");
	AST_MODE_HOLD: assert property (!(st_r.cke && cmd == sdc_pkg::CMD_LMR)
		|=> $stable(st_r.mode))
		else $error("mode word changed without load");
	AST_WRAP: assert property (st_r.b.mode != sdc_pkg::BS_IDLE
		|-> ((bcol ^ st_r.b.start) & ~bmask) == '0)
		else $error("burst left its block");
	AST_ILV: assert property (st_r.b.mode != sdc_pkg::BS_IDLE && st_r.mode[sdc_pkg::ORDER_BIT]
		&& !bfull |-> ((bcol ^ st_r.b.start) & bmask) == (st_r.b.beat & bmask))
		else $error("interleaved order wrong");
	AST_WSINGLE: assert property (acc_wr && st_r.mode[sdc_pkg::WBM_BIT]
		|=> st_r.b.mode == sdc_pkg::BS_IDLE)
		else $error("single write mode ran a burst");
endmodule // sdc_core

/* tb/sdc_ctrl_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Controller stand-in: drives commands, mask and write data
// ----------------------------------------------------------------
module sdc_ctrl_model (
	input  wire logic        sys_clk,
	output logic             cke,
	output logic             cs_n,
	output logic [2:0]       cmd_pins,
	output logic [1:0]       bank,
	output logic [11:0]      addr,
	output logic [1:0]       dqm,
	output logic [15:0]      dq_in
);
	// Power-up levels: mask and clock enable high, bus deselected
	initial begin
		cke = 1'b1;
		cs_n = 1'b1;
		cmd_pins = sdc_pkg::P_NOP;
		bank = 2'h0;
		addr = 12'h000;
		dqm = 2'h3;
		dq_in = 16'h0000;
	end

	// Drive one command; it stays until the caller moves on
	task automatic cmd(input logic [2:0] p, input logic [1:0] b, input logic [11:0] a);
		cs_n <= 1'b0;
		cmd_pins <= p;
		bank <= b;
		addr <= a;
		if (p != sdc_pkg::P_WR) dq_in <= ~dq_in;
		@(posedge sys_clk);
	endtask

	// Deselect; released lines flip so stale values never look valid
	task automatic idle(input int k, input bit keep);
		cs_n <= 1'b1;
		cmd_pins <= sdc_pkg::P_NOP;
		bank <= ~bank;
		addr <= ~addr;
		if (!keep) dq_in <= ~dq_in;
		repeat (k) @(posedge sys_clk);
	endtask

	// Write burst: word i is base+i, first word with the command
	task automatic wr(input logic [1:0] b, input logic [11:0] a, input int n,
		input logic [15:0] base, input int mb, input logic [1:0] mv);
		logic [15:0] d;
		for (int i = 0; i < n; i++) begin
			d = base + 16'(i);
			dq_in <= d;
			dqm <= (i == mb) ? mv : 2'h0;
			if (i == 0) cmd(sdc_pkg::P_WR, b, a);
			else idle(1, 1'b1);
		end
		dqm <= 2'h0;
	endtask

	// Power-up: long idle, precharge all, two refreshes
	task automatic init_seq();
		repeat (10000) @(posedge sys_clk);
		cmd(sdc_pkg::P_PRE, 2'h0, 12'h400);
		idle(2, 1'b0);
		cmd(sdc_pkg::P_REF, 2'h0, 12'h000);
		idle(6, 1'b0);
		cmd(sdc_pkg::P_REF, 2'h0, 12'h000);
		idle(6, 1'b0);
		dqm <= 2'h0;
	endtask

	// Mode load only with every bank closed, then the settle gap
	task automatic load(input logic [11:0] m);
		cmd(sdc_pkg::P_PRE, 2'h0, 12'h400);
		idle(2, 1'b0);
		cmd(sdc_pkg::P_LMR, 2'h0, m);
		idle(2, 1'b0);
	endtask
endmodule // sdc_ctrl_model

/* tb/sdc_core_mode_and_burst_tb.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bench: scoreboard keyed by edge number, one task per scenario
// ----------------------------------------------------------------
module sdc_core_mode_and_burst_tb;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cke, cs_n;
	logic [2:0]  pins;
	logic [1:0]  bank, dqm, dq_oe;
	logic [11:0] addr;
	logic [15:0] dq_in, dq_out;
	int          fails = 0;
	int          num_checks = 0;
	int          cyc = 0;              // Edges seen so far
	int          blen, lat;            // Burst length, read latency
	bit          ilv, wbm;             // Order and single-write flag
	logic [11:0] row = 12'hABC;        // Only row used, in bank 3
	logic [15:0] mem [logic [21:0]];   // Reference contents
	logic [1:0]  exp_oe [int];         // Lanes expected per edge
	logic [15:0] exp_dq [int];         // Word expected per edge

	sdc_ctrl_model i_sdc_ctrl_model (.sys_clk(sys_clk), .cke(cke), .cs_n(cs_n),
		.cmd_pins(pins), .bank(bank), .addr(addr), .dqm(dqm), .dq_in(dq_in));
	sdc_core i_sdc_core (.SYS_CLK(sys_clk), .RST_N(rst_n), .CKE(cke), .CS_N(cs_n),
		.RAS_N(pins[2]), .CAS_N(pins[1]), .WE_N(pins[0]), .BANK_SELECT_LO(bank[0]),
		.BANK_SELECT_HI(bank[1]), .ADDR(addr), .DQM(dqm), .DQ_IN(dq_in),
		.DQ_OUT(dq_out), .DQ_OE(dq_oe));

	always #5 sys_clk = ~sys_clk;

	// Edge count; the ceiling is well above init plus all scenarios
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 12000) begin
			fails++;
			tally_and_finish();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] expv);
		num_checks++;
		if (seen !== expv) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask

	// Sampled mid-cycle so edge updates have landed; idle means no lane drives
	always @(negedge sys_clk) begin : mon
		int e;
		logic [1:0] eo;
		logic [15:0] m;
		e = cyc - 1;
		eo = exp_oe.exists(e) ? exp_oe[e] : 2'h0;
		m = {{8{eo[1]}}, {8{eo[0]}}};
		if (rst_n) begin
			check({14'h0, dq_oe}, {14'h0, eo});
			if (m != 16'h0000) check(dq_out & m, exp_dq[e] & m);
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] col_of(input logic [7:0] s, input int b);
		logic [7:0] m;
		m = 8'(blen - 1);
		return (s & ~m) | ((ilv ? s ^ 8'(b) : s + 8'(b)) & m);
	endfunction

	task automatic set_mode(input logic [2:0] code, input bit o, input int l, input bit w);
		blen = (code == sdc_pkg::BL_FULL) ? 256 : (1 << code);
		ilv = o;
		lat = l;
		wbm = w;
		i_sdc_ctrl_model.load({2'h0, w, sdc_pkg::OPM_NORMAL,
			(l == 2) ? sdc_pkg::CL_CODE_2 : 3'h3, o, code});
		i_sdc_ctrl_model.cmd(sdc_pkg::P_ACT, 2'h3, row);
		i_sdc_ctrl_model.idle(2, 1'b0);
	endtask

	// Masked lanes keep the old byte
	task automatic wr(input logic [11:0] a, input int n, input logic [15:0] base,
		input int mb, input logic [1:0] mv);
		logic [21:0] k;
		logic [15:0] d;
		i_sdc_ctrl_model.wr(2'h3, a, n, base, mb, mv);
		for (int i = 0; i < (wbm ? 1 : n); i++) begin
			k = {2'h3, row, col_of(a[7:0], i)};
			d = base + 16'(i);
			if (i == mb) d = {mv[1] ? mem[k][15:8] : d[15:8], mv[0] ? mem[k][7:0] : d[7:0]};
			mem[k] = d;
		end
	endtask

	// Schedules n words from edge e = command edge + latency - 1
	task automatic rd(input logic [7:0] s, input int n, output int e);
		i_sdc_ctrl_model.cmd(sdc_pkg::P_RD, 2'h3, {4'h0, s});
		e = cyc + lat - 1;
		for (int i = 0; i < n; i++) begin
			exp_oe[e + i] = 2'h3;
			exp_dq[e + i] = mem[{2'h3, row, col_of(s, i)}];
		end
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_full_page();
		int e;
		set_mode(sdc_pkg::BL_FULL, 1'b0, 3, 1'b0);
		wr(12'h0FE, 258, 16'h1000, 256, 2'h1);
		i_sdc_ctrl_model.cmd(sdc_pkg::P_BST, 2'h3, 12'h000);
		i_sdc_ctrl_model.idle(2, 1'b0);
		rd(8'hFA, 10, e);
		i_sdc_ctrl_model.idle(2, 1'b0);
		i_sdc_ctrl_model.dqm <= 2'h1;
		i_sdc_ctrl_model.idle(1, 1'b0);
		i_sdc_ctrl_model.dqm <= 2'h0;
		exp_oe[e + 3] = 2'h2;
		// Precharge two edges before the tenth word is valid at latency three
		i_sdc_ctrl_model.idle(6, 1'b0);
		i_sdc_ctrl_model.cmd(sdc_pkg::P_PRE, 2'h3, 12'h000);
		i_sdc_ctrl_model.idle(8, 1'b0);
		$display("test full page done");
	endtask

	// Every fixed length; sequential order at latency two, interleaved order at latency three
	task automatic t_lengths();
		int e;
		for (int c = 0; c < 4; c++) begin
			for (int o = 0; o < 2; o++) begin
				set_mode(3'(c), 1'(o), 2 + o, 1'b0);
				rd(8'h35, blen, e);
				i_sdc_ctrl_model.idle(12, 1'b0);
			end
		end
		$display("test lengths done");
	endtask

	// Reads on consecutive edges, then one stretched by a clock-enable drop
	task automatic t_back_to_back();
		int e;
		set_mode(sdc_pkg::BL_1, 1'b0, 2, 1'b0);
		rd(8'h10, 1, e);
		rd(8'h11, 1, e);
		i_sdc_ctrl_model.idle(4, 1'b0);
		i_sdc_ctrl_model.cke <= 1'b0;
		rd(8'h12, 1, e);
		i_sdc_ctrl_model.cke <= 1'b1;
		exp_oe.delete(e);
		exp_oe[e + 1] = 2'h3;
		exp_dq[e + 1] = exp_dq[e];
		i_sdc_ctrl_model.idle(4, 1'b0);
		$display("test back to back done");
	endtask

	// Single-location write with auto precharge; closed bank ignores a read
	task automatic t_single_write();
		int e;
		set_mode(sdc_pkg::BL_4, 1'b0, 3, 1'b1);
		wr(12'h420, 4, 16'h7700, -1, 2'h0);
		i_sdc_ctrl_model.idle(5, 1'b0);
		i_sdc_ctrl_model.cmd(sdc_pkg::P_RD, 2'h3, 12'h020);
		i_sdc_ctrl_model.idle(2, 1'b0);
		i_sdc_ctrl_model.cmd(sdc_pkg::P_ACT, 2'h3, row);
		i_sdc_ctrl_model.idle(2, 1'b0);
		rd(8'h20, 4, e);
		i_sdc_ctrl_model.idle(8, 1'b0);
		$display("test single write done");
	endtask

	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		i_sdc_ctrl_model.init_seq();
		$display("test init done");
		t_full_page();
		t_lengths();
		t_back_to_back();
		t_single_write();
		tally_and_finish();
	end
endmodule // sdc_core_mode_and_burst_tb
